// [design/spp_pkg.sv]
// Shared constants and types for the serial peripheral port
package spp_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] SPP_CTRL_ADDR  = 8'h10; // serial_control_reg
	localparam logic [7:0] SPP_STAT_ADDR  = 8'h11;
	localparam logic [7:0] SPP_DATA_ADDR  = 8'h12; // serial_data_reg
	localparam logic [7:0] SPP_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPP_DATA_RESET = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SPP_CTRL_RATE_LSB = 0; // rate_select, two bits
	localparam int SPP_CTRL_CLOCK_PHASE_SEL_BIT = 2; // clock_phase_sel
	localparam int SPP_CTRL_CLOCK_POLARITY_SEL_BIT = 3; // clock_polarity_sel
	localparam int SPP_CTRL_MSTR_BIT = 4; // master_select
	localparam int SPP_CTRL_EN_BIT   = 5; // serial_enable
	localparam int SPP_STAT_BUSY_BIT = 0;
	localparam int SPP_STAT_DONE_BIT = 1;

	// ----------------------------------------
	// Timing counts, bus clock cycles per SCK half period
	// ----------------------------------------
	localparam logic [4:0] SPP_HALF_DIV2  = 5'h01;
	localparam logic [4:0] SPP_HALF_DIV8  = 5'h04;
	localparam logic [4:0] SPP_HALF_DIV16 = 5'h08;
	localparam logic [4:0] SPP_HALF_DIV32 = 5'h10;
	localparam logic [4:0] SPP_HALF_STEPS = 5'h10; // half periods in one byte
	localparam logic [3:0] SPP_LAST_EDGE  = 4'hf;

	// Input synchroniser slots
	localparam int SPP_IN_SCK  = 0;
	localparam int SPP_IN_SSN  = 1;
	localparam int SPP_IN_MOSI = 2;
	localparam int SPP_IN_MISO = 3;
	localparam int SPP_IN_NUM  = 4;

	typedef enum logic [1:0] {
		SPP_M_IDLE = 2'b00,
		SPP_M_WAIT = 2'b01,
		SPP_M_RUN  = 2'b10
	} spp_mstate_type;

	// Half period length for a rate code
	function automatic logic [4:0] spp_half_len(input logic [1:0] rate);
		unique case (rate)
			2'h0: spp_half_len = SPP_HALF_DIV2;
			2'h1: spp_half_len = SPP_HALF_DIV8;
			2'h2: spp_half_len = SPP_HALF_DIV16;
			2'h3: spp_half_len = SPP_HALF_DIV32;
		endcase
	endfunction

endpackage

// [design/spp_shift_if.sv]
// Control and data bundle between the port core and its shifter
`timescale 1ns/1ps
`default_nettype none
interface spp_shift_if;
	logic       load;
	logic [7:0] load_data;
	logic       capture;
	logic       shift;
	logic       capshift;
	logic       din;
	logic       tx_bit;
	logic [7:0] sr;

	modport ctl (output load, output load_data, output capture, output shift,
		output capshift, output din, input tx_bit, input sr);
	modport shf (input load, input load_data, input capture, input shift,
		input capshift, input din, output tx_bit, output sr);
endinterface
`default_nettype wire

// [design/spp_rate_div.sv]
// Free-running shift clock divider with half period and cycle boundary ticks
`timescale 1ns/1ps
`default_nettype none
module spp_rate_div
	import spp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [1:0] rate,
	output var  logic       half_tick,
	output var  logic       bound
);
	logic [4:0] cnt_reg;
	logic       phase_reg;

	// ----------------------------------------
	// Divider, stopped and cleared unless run
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= 5'h00;
			phase_reg <= 1'b0;
			half_tick <= 1'b0;
			bound     <= 1'b0;
		end else if (!run) begin
			cnt_reg   <= 5'h00;
			phase_reg <= 1'b0;
			half_tick <= 1'b0;
			bound     <= 1'b0;
		end else if (cnt_reg >= spp_half_len(rate) - 5'h01) begin
			cnt_reg   <= 5'h00;
			phase_reg <= ~phase_reg;
			half_tick <= 1'b1;
			bound     <= ~phase_reg; // Every second tick opens an SCK cycle
		end else begin
			cnt_reg   <= cnt_reg + 5'h01;
			half_tick <= 1'b0;
			bound     <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [design/spp_shifter.sv]
// Eight bit MSB-first transmit shifter and delayed receive shifter
`timescale 1ns/1ps
`default_nettype none
module spp_shifter
	import spp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	spp_shift_if.shf  sh
);
	logic [7:0] sr_reg;
	logic [7:0] rx_reg;
	logic       samp_d1_reg;
	logic       samp_d2_reg;

	// Next MSB, so a registered pin changes on the same clock as SCK
	assign sh.sr     = rx_reg;
	assign sh.tx_bit = sh.load ? sh.load_data[7] :
		(sh.shift || sh.capshift) ? sr_reg[6] : sr_reg[7];

	// ----------------------------------------
	// Load and shift the outgoing byte
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_reg <= SPP_DATA_RESET;
		end else if (sh.load) begin
			sr_reg <= sh.load_data;
		end else if (sh.capshift || sh.shift) begin
			sr_reg <= {sr_reg[6:0], 1'b0};
		end
	end

	// ----------------------------------------
	// Receive, sample strobe delayed two clocks
	// ----------------------------------------
	// Matches the two pin synchroniser flops, so the bit sampled is the one
	// that stood on the pin at the sampling SCK edge, even at divide by two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_d1_reg <= 1'b0;
			samp_d2_reg <= 1'b0;
			rx_reg      <= SPP_DATA_RESET;
		end else begin
			samp_d1_reg <= sh.capture || sh.capshift;
			samp_d2_reg <= samp_d1_reg;
			if (samp_d2_reg) begin
				rx_reg <= {rx_reg[6:0], sh.din};
			end
		end
	end
endmodule
`default_nettype wire

// [design/spp_core.sv]
// Serial peripheral port core: registers, master sequencer, slave engine
// Function
// - Slave drives MISO only while selected
// - Master holds its own select pin high
// - Phase one: master drives MOSI at first edge
// - Phase one: slave starts at first edge
// - Phase one: select may stay low between bytes
// - Master data write starts a transfer
// - Phase leaves start delay unchanged
// - Phase zero: SCK idles first half cycle
// - Phase one: first cycle opens with edge
// - Rate select sets start delay
// - Divider runs only when enabled master
// - SCK changes on bus clock rising edge
// - Start waits for next SCK cycle boundary
// - SCK, MISO, MOSI wired straight across
`timescale 1ns/1ps
`default_nettype none
module spp_core
	import spp_pkg::*;
(
	input  wire logic       CORE_CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	input  wire logic       SCK_IN,
	output var  logic       SCK_OUT,
	output var  logic       SCK_OE,
	input  wire logic       MOSI_IN,
	output var  logic       MOSI_OUT,
	output var  logic       MOSI_OE,
	input  wire logic       MISO_IN,
	output var  logic       MISO_OUT,
	output var  logic       MISO_OE,
	input  wire logic       SS_N_IN,
	output var  logic       SS_N_OUT,
	output var  logic       SS_N_OE
);
	import spp_pkg::*;

	spp_shift_if sh ();

	logic [7:0]          ctrl_reg;
	logic [7:0]          rx_reg;
	logic                done_flag_reg;
	logic                done_d_reg;
	logic                done_d2_reg;
	logic                done_d3_reg;
	spp_mstate_type      mstate_reg;
	logic [4:0]          step_reg;
	logic [3:0]          slv_cnt_reg;
	logic                sck_dly_reg;
	logic [SPP_IN_NUM-1:0] sync1_reg;
	logic [SPP_IN_NUM-1:0] sync2_reg;

	logic       clock_phase_sel;
	logic       clock_polarity_sel;
	logic       mstr;
	logic       en;
	logic       mrun;
	logic       half_tick;
	logic       bound;
	logic       start;
	logic [4:0] step_next;
	logic       m_edge;
	logic [3:0] m_n;
	logic       m_end;
	logic       s_sel;
	logic       s_edge;
	logic       edge_any;
	logic [3:0] edge_n;
	logic       done;
	logic       busy;
	logic       wr_data;
	logic       rd_data;

	assign clock_phase_sel    = ctrl_reg[SPP_CTRL_CLOCK_PHASE_SEL_BIT];
	assign clock_polarity_sel    = ctrl_reg[SPP_CTRL_CLOCK_POLARITY_SEL_BIT];
	assign mstr    = ctrl_reg[SPP_CTRL_MSTR_BIT];
	assign en      = ctrl_reg[SPP_CTRL_EN_BIT];
	assign mrun    = en & mstr;
	assign wr_data = WR && (ADDR == SPP_DATA_ADDR);
	assign rd_data = RD && (ADDR == SPP_DATA_ADDR);

	// ----------------------------------------
	// Input synchronisers, two flops per pin
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < SPP_IN_NUM; gi++) begin : g_sync
			logic pin;
			if (gi == SPP_IN_SCK) begin : g_sck
				assign pin = SCK_IN;
			end else if (gi == SPP_IN_SSN) begin : g_ssn
				assign pin = SS_N_IN;
			end else if (gi == SPP_IN_MOSI) begin : g_mosi
				assign pin = MOSI_IN;
			end else begin : g_miso
				assign pin = MISO_IN;
			end
			always_ff @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= pin;
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Shift clock divider and shifter
	// ----------------------------------------
	// Divider is free-running and powered only as enabled master
	spp_rate_div u_div (
		.clk       (CORE_CLK),
		.rst_n     (RESETN),
		.run       (mrun),
		.rate      (ctrl_reg[SPP_CTRL_RATE_LSB +: 2]),
		.half_tick (half_tick),
		.bound     (bound)
	);

	spp_shifter u_shf (
		.clk   (CORE_CLK),
		.rst_n (RESETN),
		.sh    (sh.shf)
	);

	// ----------------------------------------
	// Master step decode
	// ----------------------------------------
	// Start only on a cycle boundary, so delay depends on where the write fell
	assign start     = (mstate_reg == SPP_M_WAIT) && bound && mrun;
	assign step_next = step_reg + 5'h01;
	always_comb begin
		m_edge = 1'b0;
		m_n    = 4'h0;
		m_end  = 1'b0;
		if (start) begin
			m_edge = clock_phase_sel; // Phase one edge opens the first cycle
		end else if ((mstate_reg == SPP_M_RUN) && half_tick) begin
			m_end = (step_next == SPP_HALF_STEPS);
			if (clock_phase_sel) begin
				m_edge = !m_end;
				m_n    = step_next[3:0];
			end else begin
				m_edge = 1'b1; // First half cycle already passed idle
				m_n    = step_reg[3:0];
			end
		end
	end

	// ----------------------------------------
	// Slave edge decode
	// ----------------------------------------
	assign s_sel  = en && !mstr && !sync2_reg[SPP_IN_SSN];
	assign s_edge = s_sel && (sync2_reg[SPP_IN_SCK] != sck_dly_reg);
	assign busy   = (mstate_reg != SPP_M_IDLE) || (s_sel && (slv_cnt_reg != 4'h0));

	assign edge_any = mrun ? m_edge : s_edge;
	assign edge_n   = mrun ? m_n : slv_cnt_reg;
	assign done     = edge_any && (edge_n == SPP_LAST_EDGE);

	// ----------------------------------------
	// Shifter control per edge number
	// ----------------------------------------
	always_comb begin
		sh.load      = wr_data && !busy;
		sh.load_data = WDATA;
		sh.din       = mrun ? sync2_reg[SPP_IN_MISO] : sync2_reg[SPP_IN_MOSI];
		sh.capture   = 1'b0;
		sh.shift     = 1'b0;
		sh.capshift  = 1'b0;
		if (edge_any) begin
			if (!clock_phase_sel) begin
				sh.capture = !edge_n[0];
				sh.shift   = edge_n[0];
			end else if (edge_n == SPP_LAST_EDGE) begin
				sh.capshift = 1'b1;
			end else begin
				// Edge zero only starts the byte
				sh.capture = edge_n[0];
				sh.shift   = !edge_n[0] && (edge_n != 4'h0);
			end
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_reg <= SPP_CTRL_RESET;
		end else if (WR && (ADDR == SPP_CTRL_ADDR)) begin
			ctrl_reg <= {2'h0, WDATA[5:0]};
		end
	end

	// ----------------------------------------
	// Master sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mstate_reg <= SPP_M_IDLE;
			step_reg   <= 5'h00;
		end else if (!mrun) begin
			mstate_reg <= SPP_M_IDLE;
			step_reg   <= 5'h00;
		end else begin
			unique case (mstate_reg)
				SPP_M_IDLE: begin
					if (wr_data) begin
						mstate_reg <= SPP_M_WAIT;
					end
				end
				SPP_M_WAIT: begin
					if (start) begin
						mstate_reg <= SPP_M_RUN;
						step_reg   <= 5'h00;
					end
				end
				SPP_M_RUN: begin
					if (half_tick) begin
						step_reg <= step_next;
						if (m_end) begin
							mstate_reg <= SPP_M_IDLE;
						end
					end
				end
				default: begin
					mstate_reg <= SPP_M_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Slave edge counter
	// ----------------------------------------
	// Counter wraps so select may stay low across bytes
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			slv_cnt_reg <= 4'h0;
			sck_dly_reg <= 1'b1; // Matches synchroniser reset, no false edge
		end else begin
			sck_dly_reg <= sync2_reg[SPP_IN_SCK];
			if (!s_sel) begin
				slv_cnt_reg <= 4'h0;
			end else if (s_edge) begin
				slv_cnt_reg <= slv_cnt_reg + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	// SCK toggles one bus clock after its tick, never mid-phase of it
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			SCK_OUT  <= 1'b0;
			SCK_OE   <= 1'b0;
			MOSI_OUT <= 1'b0;
			MOSI_OE  <= 1'b0;
			MISO_OUT <= 1'b0;
			MISO_OE  <= 1'b0;
			SS_N_OUT <= 1'b1;
			SS_N_OE  <= 1'b0;
		end else begin
			if (mrun && m_edge) begin
				SCK_OUT <= ~SCK_OUT;
			end else if (!mrun || (mstate_reg != SPP_M_RUN) || m_end) begin
				SCK_OUT <= clock_polarity_sel;
			end
			SCK_OE   <= mrun;
			MOSI_OUT <= sh.tx_bit;
			if (start) begin
				MOSI_OE <= 1'b1;
			end else if (!mrun || m_end) begin
				MOSI_OE <= 1'b0;
			end
			MISO_OUT <= sh.tx_bit;
			MISO_OE  <= s_sel;
			SS_N_OUT <= 1'b1;
			SS_N_OE  <= mrun;
		end
	end

	// ----------------------------------------
	// Receive buffer and done flag
	// ----------------------------------------
	// A completion in the clearing cycle keeps the flag set
	// Done waits three clocks for the delayed last receive sample
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			done_d_reg    <= 1'b0;
			done_d2_reg   <= 1'b0;
			done_d3_reg   <= 1'b0;
			rx_reg        <= SPP_DATA_RESET;
			done_flag_reg <= 1'b0;
		end else begin
			done_d_reg  <= done;
			done_d2_reg <= done_d_reg;
			done_d3_reg <= done_d2_reg;
			if (done_d3_reg) begin
				rx_reg        <= sh.sr;
				done_flag_reg <= 1'b1;
			end else if (rd_data) begin
				done_flag_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				SPP_CTRL_ADDR: RDATA <= ctrl_reg;
				SPP_STAT_ADDR: RDATA <= {6'h00, done_flag_reg, busy};
				SPP_DATA_ADDR: RDATA <= rx_reg;
				default:       RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	sequence s_start_ph0;
		start && !clock_phase_sel;
	endsequence
	sequence s_idle_half;
		(SCK_OUT == clock_polarity_sel) throughout (##[0:16] half_tick);
	endsequence

	miso_select_a: assert property (MISO_OE |-> $past(s_sel))
		else $error("MISO driven while not selected");
	master_ss_a: assert property (mrun |=> SS_N_OUT && SS_N_OE)
		else $error("master select pin not held high");
	mosi_first_a: assert property (start && clock_phase_sel |=> MOSI_OE)
		else $error("MOSI not driven at first edge");
	slave_start_a: assert property (s_edge && clock_phase_sel && slv_cnt_reg == 4'h0 |=> slv_cnt_reg == 4'h1)
		else $error("slave missed start edge");
	slave_wrap_a: assert property (s_edge && done && s_sel |=> slv_cnt_reg == 4'h0)
		else $error("slave count did not wrap");
	write_start_a: assert property (wr_data && mrun && mstate_reg == SPP_M_IDLE |=> mstate_reg == SPP_M_WAIT)
		else $error("data write did not request start");
	start_bound_a: assert property (mstate_reg == SPP_M_WAIT && mrun |-> ##[0:64] (start || !mrun))
		else $error("start not reached within a cycle");
	phase0_idle_a: assert property (s_start_ph0 |=> s_idle_half)
		else $error("SCK left idle in first half cycle");
	phase1_edge_a: assert property (start && clock_phase_sel |=> SCK_OUT != $past(clock_polarity_sel))
		else $error("phase one cycle lacks opening edge");
	div_stop_a: assert property (!mrun |=> !half_tick)
		else $error("divider runs while not enabled master");
	idle_level_a: assert property (mstate_reg != SPP_M_RUN && !start |=> SCK_OUT == $past(clock_polarity_sel))
		else $error("idle SCK does not follow polarity");
endmodule
`default_nettype wire

// [bench/spp_peer.sv]
// Behavioural slave device facing the port while it acts as master
`timescale 1ns/1ps
`default_nettype none
module spp_peer (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic       phase,
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output var  logic       miso,
	output var  logic [7:0] rx
);
	// ----------------------------------------
	// Slave shifter
	// ----------------------------------------
	logic [7:0] txb      = 8'h00;
	logic       ob       = 1'b0;
	logic       mosi_old = 1'b1;
	int         e        = 0;
	int         dc       = 0;

	initial rx = 8'h00;

	// MOSI as it stood just before any SCK edge, so sampling never races
	always @(mosi) mosi_old <= #1 mosi;

	// New answer byte, MSB ready before the first edge
	always @(posedge load) begin
		txb = tx;
		ob = tx[7];
		e = 0;
		dc = phase ? 0 : 1;
	end

	// Edge count per byte; sample on one kind of edge, drive on the other
	always @(sck) begin
		if (!sel_n) begin
			e = e + 1;
			if ((e % 2 == 1) == !phase) begin
				rx = {rx[6:0], mosi_old};
			end else if (dc < 8) begin
				ob = txb[7 - dc];
				dc = dc + 1;
			end
			if (e == 16) e = 0;
		end
	end

	// Inverted level once deselected, so a stale bit never looks valid
	assign miso = sel_n ? ~ob : ob;
endmodule
`default_nettype wire

// [bench/spi_phase_one_and_start_latency_tb.sv]
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module spi_phase_one_and_start_latency_tb;
	import spp_pkg::*;

	// ----------------------------------------
	// Signals and wiring
	// ----------------------------------------
	logic       clk         = 1'b0;
	logic       rst_n       = 1'b0;
	logic [7:0] addr        = 8'h00;
	logic [7:0] wdata       = 8'h00;
	logic       wr          = 1'b0;
	logic       rd          = 1'b0;
	logic [7:0] rdata;
	logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
	logic       tb_sck      = 1'b0;
	logic       tb_mosi     = 1'b1;
	logic       tb_ss_n     = 1'b1;
	logic       peer_sel_n  = 1'b1;
	logic       peer_phase  = 1'b0;
	logic       peer_load   = 1'b0;
	logic [7:0] peer_tx     = 8'h00;
	logic       peer_miso;
	logic [7:0] peer_rx;
	int         fail_count  = 0;
	int         comparisons = 0;
	wire logic  sck_w       = sck_oe ? sck_o : tb_sck;
	wire logic  mosi_w      = mosi_oe ? mosi_o : tb_mosi;
	wire logic  miso_w      = miso_oe ? miso_o : peer_miso;
	wire logic  ss_w        = ss_oe ? ss_o : tb_ss_n;

	// Bus clock, 100 MHz
	always #5 clk = ~clk;

	spp_core dut (
		.CORE_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE(sck_oe),
		.MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_IN(miso_w),
		.MISO_OUT(miso_o), .MISO_OE(miso_oe), .SS_N_IN(ss_w), .SS_N_OUT(ss_o),
		.SS_N_OE(ss_oe)
	);

	spp_peer peer (
		.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .phase(peer_phase),
		.load(peer_load), .tx(peer_tx), .miso(peer_miso), .rx(peer_rx)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, unmapped place, and no transfer while disabled
	task automatic t_regs;
		logic [7:0] v;
		rd_reg(SPP_CTRL_ADDR, v);
		chk(v, SPP_CTRL_RESET);
		rd_reg(SPP_DATA_ADDR, v);
		chk(v, SPP_DATA_RESET);
		wr_reg(8'h3f, 8'hff);
		rd_reg(8'h3f, v);
		chk(v, 8'h00);
		wr_reg(SPP_CTRL_ADDR, 8'hcf);
		rd_reg(SPP_CTRL_ADDR, v);
		chk(v, 8'h0f);
		wr_reg(SPP_DATA_ADDR, 8'ha5);
		repeat (40) begin
			@(posedge clk);
			#1;
			chk({5'h0, sck_oe, mosi_oe, ss_oe}, 8'h00);
		end
		wr_reg(SPP_CTRL_ADDR, 8'h00);
	endtask

	// One master byte: start delay, first edge, edge count, data both ways
	task automatic t_master(input logic ph, input logic pol, input logic [1:0] rt,
		input logic [7:0] tx, input logic [7:0] ptx);
		int         h;
		int         lat;
		int         tog;
		logic       prev;
		logic [7:0] v;
		h = (rt == 2'h0) ? 1 : (2 << rt);
		wr_reg(SPP_CTRL_ADDR, {2'b00, 1'b1, 1'b1, pol, ph, rt});
		repeat (4) @(posedge clk);
		peer_phase <= ph;
		peer_tx <= ptx;
		peer_sel_n <= 1'b0;
		peer_load <= 1'b1;
		@(posedge clk);
		peer_load <= 1'b0;
		#1;
		chk({4'h0, sck_oe, ss_oe, ss_o, sck_o}, {4'h0, 3'b111, pol});
		prev = pol;
		lat = 0;
		tog = 0;
		wr_reg(SPP_DATA_ADDR, tx);
		for (int n = 1; n < 20 * h + 20; n++) begin
			@(posedge clk);
			#1;
			if (lat == 0 && mosi_oe === 1'b1) begin
				lat = n;
				chk({7'h0, sck_o}, {7'h0, pol ^ ph});
			end
			if (sck_o !== prev) begin
				tog++;
				prev = sck_o;
			end
			if (lat != 0 && mosi_oe !== 1'b1) break;
		end
		chk({7'h0, lat >= 1 && lat <= 2 * h + 3}, 8'h01);
		chk(tog[7:0], 8'd16);
		chk({7'h0, sck_o}, {7'h0, pol});
		repeat (4) @(posedge clk);
		rd_reg(SPP_STAT_ADDR, v);
		chk(v, 8'h02);
		rd_reg(SPP_DATA_ADDR, v);
		chk(v, ptx);
		chk(peer_rx, tx);
		chk({7'h0, miso_oe}, 8'h00);
		peer_sel_n <= 1'b1;
	endtask

	// Bench as master: one byte over SCK_IN at 160 ns, MISO captured
	task automatic send_byte(input logic [7:0] m, output logic [7:0] cap);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			tb_sck <= 1'b1;
			tb_mosi <= m[i];
			repeat (7) @(posedge clk);
			#1;
			cap = {cap[6:0], miso_w};
			@(posedge clk);
			tb_sck <= 1'b0;
			repeat (7) @(posedge clk);
		end
	endtask

	// Port as phase-one slave, select held low across two bytes
	task automatic t_slave(input logic [7:0] a, input logic [7:0] m1, input logic [7:0] m2);
		logic [7:0] cap;
		logic [7:0] v;
		wr_reg(SPP_CTRL_ADDR, 8'h24);
		wr_reg(SPP_DATA_ADDR, a);
		repeat (6) @(posedge clk);
		#1;
		chk({5'h0, miso_oe, sck_oe, ss_oe}, 8'h00);
		@(posedge clk);
		tb_ss_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk({7'h0, miso_oe}, 8'h01);
		send_byte(m1, cap);
		chk(cap, a);
		repeat (8) @(posedge clk);
		rd_reg(SPP_DATA_ADDR, v);
		chk(v, m1);
		send_byte(m2, cap);
		repeat (8) @(posedge clk);
		rd_reg(SPP_DATA_ADDR, v);
		chk(v, m2);
		@(posedge clk);
		tb_ss_n <= 1'b1;
		tb_mosi <= ~tb_mosi;
		repeat (6) @(posedge clk);
		#1;
		chk({7'h0, miso_oe}, 8'h00);
		wr_reg(SPP_CTRL_ADDR, 8'h00);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_master(1'b1, 1'b0, 2'h0, 8'h96, 8'h3c);
		t_master(1'b1, 1'b1, 2'h1, 8'h81, 8'he7);
		t_master(1'b0, 1'b0, 2'h2, 8'h5a, 8'h01);
		t_master(1'b0, 1'b1, 2'h3, 8'h7e, 8'ha4);
		t_slave(8'hc3, 8'h69, 8'h18);
		close_out;
	end

	// Some 1000 cycles expected; cut off at ten times that
	initial begin
		#100000;
		fail_count++;
		close_out;
	end
endmodule
`default_nettype wire
